// *** inc/scpc_regs.svh ***
// Register offsets, field positions and reset values of the pin controller
`ifndef SCPC_REGS_SVH
`define SCPC_REGS_SVH

// Byte offsets of the APB registers
`define SCPC_CTRL_A_OFS   12'h000
`define SCPC_CTRL_B_OFS   12'h004
`define SCPC_STATUS_OFS   12'h008
`define SCPC_MASK_OFS     12'h00C
`define SCPC_PINS_OFS     12'h010

// Channel control word layout
`define SCPC_CFG_W        14
`define SCPC_F_RTS        0
`define SCPC_F_DTR        1
`define SCPC_F_ASYNC      2
`define SCPC_F_AUTO       3
`define SCPC_F_RTS_GPO    4
`define SCPC_F_RTS_VAL    5
`define SCPC_F_DTR_MODE   6
`define SCPC_F_DTR_VAL    8
`define SCPC_F_CLK_SEL    9
`define SCPC_F_MULT       11
`define SCPC_F_XTAL       13

// Event bits of status and mask
`define SCPC_EV_W         5
`define SCPC_EV_REL_A     0
`define SCPC_EV_REL_B     1
`define SCPC_EV_START_A   2
`define SCPC_EV_START_B   3
`define SCPC_EV_IRQ_ACK_IN_N    4

// Reset values and synchroniser width
`define SCPC_CTRL_RST     14'h0000
`define SCPC_MASK_RST     5'h00
`define SCPC_SYNC_W       7

`endif

// *** inc/scpc_pkg.sv ***
// Types shared by the pin controller modules
package scpc_pkg;

  typedef logic [13:0] scpc_cfg_t;

  // APB slave phase
  typedef enum logic {
    APB_IDLE,
    APB_ACK
  } scpc_apb_e;

  // Per-channel modem and clock pin state
  typedef struct packed {
    logic       rts_act;
    logic       rts_n;
    logic       dtr_n;
    logic       rtxc_prev;
    logic       rxd_prev;
    logic [5:0] div_cnt;
    logic       bit_tick;
    logic [3:0] route;
    logic       osc_en;
    logic       rel_ev;
    logic       start_ev;
  } scpc_chan_s;

  // Top-level state: synchronisers, registers and bus slave
  typedef struct packed {
    logic [6:0]       sy1;
    logic [6:0]       sy2;
    logic             ack_prev;
    logic [1:0][13:0] ctrl;
    logic [4:0]       status;
    logic [4:0]       mask;
    logic [4:0]       clr;
    scpc_apb_e        apb;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             irq_n;
    logic             irq_oe;
    logic             int_lvl;
    logic             data_oe;
  } scpc_top_s;

endpackage : scpc_pkg

// *** inc/scpc_chan_if.sv ***
// Control and status bundle between the top and one channel
`timescale 1ns/1ps
interface scpc_chan_if;
  scpc_pkg::scpc_cfg_t cfg;
  logic                tx_empty;
  logic                dma_req;
  logic                rtxc_lvl;
  logic                rxd_lvl;
  logic                rts_n;
  logic                dtr_n;
  logic                bit_tick;
  logic [3:0]          route;
  logic                osc_en;
  logic                rel_ev;
  logic                start_ev;

  // Top side drives settings and synchronised pins
  modport ctl (output cfg, tx_empty, dma_req, rtxc_lvl, rxd_lvl,
               input rts_n, dtr_n, bit_tick, route, osc_en, rel_ev,
               start_ev);
  // Channel side drives modem pins and clock strobes
  modport chan (input cfg, tx_empty, dma_req, rtxc_lvl, rxd_lvl,
                output rts_n, dtr_n, bit_tick, route, osc_en, rel_ev,
                start_ev);
endinterface : scpc_chan_if

// *** design/scpc_chan.sv ***
// One serial channel: modem outputs, clock pin routing and divider
`timescale 1ns/1ps
`include "scpc_regs.svh"
module scpc_chan (
  input  wire logic   clk_i,
  input  wire logic   reset_n_i,
  input  wire logic   ce_i,
  scpc_chan_if.chan   ch
);

  scpc_pkg::scpc_chan_s r_r;
  scpc_pkg::scpc_chan_s r_nxt;
  logic                 auto_on;
  logic                 clk_edge;
  logic [1:0]           dmode;

  // Receive clock factor as a divider terminal count
  function automatic logic [5:0] div_tc(input logic [1:0] mult,
                                        input logic       async_md);
    logic [5:0] tc;
    case (mult)
      2'h1:    tc = 6'h0F;
      2'h2:    tc = 6'h1F;
      2'h3:    tc = 6'h3F;
      default: tc = 6'h00;
    endcase
    // Sync modes run the clock at bit rate
    div_tc = async_md ? tc : 6'h00;
  endfunction : div_tc

  assign auto_on  = ch.cfg[`SCPC_F_ASYNC] & ch.cfg[`SCPC_F_AUTO];
  assign clk_edge = ch.rtxc_lvl & ~r_r.rtxc_prev;
  assign dmode    = ch.cfg[`SCPC_F_DTR_MODE +: 2];

  // Next state of the channel
  always_comb begin
    r_nxt           = r_r;
    r_nxt.rel_ev    = 1'b0;
    r_nxt.bit_tick  = 1'b0;
    r_nxt.route     = 4'h0;
    r_nxt.rtxc_prev = ch.rtxc_lvl;
    r_nxt.rxd_prev  = ch.rxd_lvl;
    r_nxt.start_ev  = r_r.rxd_prev & ~ch.rxd_lvl;
    r_nxt.osc_en    = ch.cfg[`SCPC_F_XTAL];                 // [RL11]
    // Auto mode keeps the request up until the shifter drains
    if (ch.cfg[`SCPC_F_RTS]) begin
      r_nxt.rts_act = 1'b1;                                 // [RL6]
    end else if (auto_on) begin
      if (ch.tx_empty) begin
        r_nxt.rts_act = 1'b0;                               // [RL7]
      end
    end else begin
      r_nxt.rts_act = 1'b0;                                 // [RL8]
    end
    r_nxt.rel_ev = r_r.rts_act & ~r_nxt.rts_act & auto_on;
    // General-purpose use overrides the modem function
    if (ch.cfg[`SCPC_F_RTS_GPO]) begin
      r_nxt.rts_n = ~ch.cfg[`SCPC_F_RTS_VAL];               // [RL9]
    end else begin
      r_nxt.rts_n = ~r_nxt.rts_act;
    end
    case (dmode)
      2'h0:    r_nxt.dtr_n = ~ch.cfg[`SCPC_F_DTR];          // [RL1]
      2'h1:    r_nxt.dtr_n = ~ch.cfg[`SCPC_F_DTR_VAL];      // [RL1]
      2'h2:    r_nxt.dtr_n = ~ch.dma_req;                   // [RL1]
      default: r_nxt.dtr_n = 1'b1;
    endcase
    // Clock pin edge goes to one consumer and to the divider
    if (clk_edge) begin
      r_nxt.route = 4'(4'h1 << ch.cfg[`SCPC_F_CLK_SEL +: 2]);  // [RL10]
      if (r_r.div_cnt >= div_tc(ch.cfg[`SCPC_F_MULT +: 2],
                                ch.cfg[`SCPC_F_ASYNC])) begin
        r_nxt.div_cnt  = 6'h00;                             // [RL12]
        r_nxt.bit_tick = 1'b1;
      end else begin
        r_nxt.div_cnt = 6'(r_r.div_cnt + 6'h01);
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_r <= '{rts_n: 1'b1, dtr_n: 1'b1, rtxc_prev: 1'b1,
               rxd_prev: 1'b1, default: '0};
    end else if (ce_i) begin
      r_r <= r_nxt;
    end
  end

  assign ch.rts_n    = r_r.rts_n;
  assign ch.dtr_n    = r_r.dtr_n;
  assign ch.bit_tick = r_r.bit_tick;
  assign ch.route    = r_r.route;
  assign ch.osc_en   = r_r.osc_en;
  assign ch.rel_ev   = r_r.rel_ev;
  assign ch.start_ev = r_r.start_ev;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_rts_set;
    ce_i && ch.cfg[`SCPC_F_RTS] && !ch.cfg[`SCPC_F_RTS_GPO] |=> !ch.rts_n;
  endproperty
  a_rts_set: assert property (p_rts_set)   // [RL6]
    else $error("send request not low after bit set");

  property p_rts_hold;
    ce_i && auto_on && !ch.cfg[`SCPC_F_RTS] && !ch.cfg[`SCPC_F_RTS_GPO]
      && !ch.tx_empty && !ch.rts_n |=> !ch.rts_n;
  endproperty
  a_rts_hold: assert property (p_rts_hold)   // [RL7]
    else $error("send request dropped before transmitter empty");

  property p_rts_track;
    ce_i && !auto_on && !ch.cfg[`SCPC_F_RTS_GPO]
      |=> ch.rts_n == !$past(ch.cfg[`SCPC_F_RTS]);
  endproperty
  a_rts_track: assert property (p_rts_track)   // [RL8]
    else $error("send request not following bit");

  property p_rts_gpo;
    ce_i && ch.cfg[`SCPC_F_RTS_GPO]
      |=> ch.rts_n == !$past(ch.cfg[`SCPC_F_RTS_VAL]);
  endproperty
  a_rts_gpo: assert property (p_rts_gpo)   // [RL9]
    else $error("send request pin not at general output value");

  property p_dtr;
    ce_i && dmode == 2'h0 |=> ch.dtr_n == !$past(ch.cfg[`SCPC_F_DTR]);
  endproperty
  a_dtr: assert property (p_dtr)   // [RL1]
    else $error("terminal ready pin not following bit");

  property p_route;
    ce_i && clk_edge |=> $onehot(ch.route) && ch.route[$past(
      ch.cfg[`SCPC_F_CLK_SEL +: 2])];
  endproperty
  a_route: assert property (p_route)   // [RL10]
    else $error("clock edge routed to wrong consumer");

  property p_tick_x1;
    ce_i && clk_edge && ch.cfg[`SCPC_F_MULT +: 2] == 2'h0 |=> ch.bit_tick;
  endproperty
  a_tick_x1: assert property (p_tick_x1)   // [RL12]
    else $error("times one clock did not give a bit strobe");

endmodule : scpc_chan

// *** design/scpc_top.sv ***
// Dual-channel serial pin controller with APB register access
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "scpc_regs.svh"
// What this block does
// RL1 - Terminal-ready pin shows its bit, a general output or DMA request.
// RL2 - Open-drain interrupt request is pulled low while one is pending.
// RL3 - Interrupt acknowledge is sampled on the rising master clock edge.
// RL4 - Host inputs are synchronised to the master clock, of free phase.
// RL5 - Select plus read strobe switches the data bus drivers on.
// RL6 - Setting a channel's send-request bit drives its pin low.
// RL7 - Async with auto enables: pin stays low until transmitter empties.
// RL8 - Sync mode or no auto enables: pin follows the bit directly.
// RL9 - The send-request pin can be a plain general-purpose output.
// RL10 - Clock pin can feed receive, transmit, rate generator or loop clock.
// RL11 - Only channel A's clock pin forms an oscillator with its sync pin.
// RL12 - The async receive clock may be 1, 16, 32 or 64 times the bit rate.
// RL13 - Both channels behave alike, each under its own control bits.
module scpc_top (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        irq_ack_in_n_i,
  input  wire logic        cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        rx_tx_clock_pin_a_n_i,
  input  wire logic        rx_tx_clock_pin_b_n_i,
  input  wire logic        serial_in_a_i,
  input  wire logic        serial_in_b_i,
  input  wire logic [1:0]  tx_empty_i,
  input  wire logic [1:0]  dma_req_i,
  output logic             send_request_a_n_o,
  output logic             send_request_b_n_o,
  output logic             term_ready_or_dma_req_a_n_o,
  output logic             term_ready_or_dma_req_b_n_o,
  output logic             irq_n_o,
  output logic             irq_oe_o,
  output logic             int_o,
  output logic             data_oe_o,
  output logic [3:0]       a_clk_route_o,
  output logic [3:0]       b_clk_route_o,
  output logic             a_bit_tick_o,
  output logic             b_bit_tick_o,
  output logic             xtal_osc_en_o
);

  scpc_pkg::scpc_top_s r_r;
  scpc_pkg::scpc_top_s r_nxt;
  logic [6:0]          pins_raw;
  logic [4:0]          ev;
  logic                ack_fall;
  logic                bus_req;
  logic                is_mapped;
  logic [31:0]         rd_word;

  scpc_chan_if ch_if[2] ();

  // Address decode shared by the read and write paths
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    case (a)
      `SCPC_CTRL_A_OFS: reg_sel = 3'h1;
      `SCPC_CTRL_B_OFS: reg_sel = 3'h2;
      `SCPC_STATUS_OFS: reg_sel = 3'h3;
      `SCPC_MASK_OFS:   reg_sel = 3'h4;
      `SCPC_PINS_OFS:   reg_sel = 3'h5;
      default:          reg_sel = 3'h0;
    endcase
  endfunction : reg_sel

  // Raw pin inputs, all from outside this clock domain
  assign pins_raw = {serial_in_b_i, serial_in_a_i, rx_tx_clock_pin_b_n_i,
                     rx_tx_clock_pin_a_n_i, rd_n_i, cs_n_i,
                     irq_ack_in_n_i};

  // Both channels built alike, each on its own control word
  for (genvar g = 0; g < 2; g++) begin : g_chan
    assign ch_if[g].cfg      = r_r.ctrl[g];                 // [RL13]
    assign ch_if[g].tx_empty = tx_empty_i[g];
    assign ch_if[g].dma_req  = dma_req_i[g];
    assign ch_if[g].rtxc_lvl = ~r_r.sy2[3 + g];
    assign ch_if[g].rxd_lvl  = r_r.sy2[5 + g];
    scpc_chan u_chan (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .ce_i      (ce_i),
      .ch        (ch_if[g])
    );
  end

  // Events feeding the sticky status bits
  assign ack_fall = r_r.ack_prev & ~r_r.sy2[0];             // [RL3]
  assign ev = {ack_fall, ch_if[1].start_ev, ch_if[0].start_ev,
               ch_if[1].rel_ev, ch_if[0].rel_ev};
  assign bus_req   = psel_i & penable_i;
  assign is_mapped = reg_sel(paddr_i) != 3'h0;

  // Read mux; pin view shows synchronised levels and driven outputs
  always_comb begin
    rd_word = 32'h0000_0000;
    case (reg_sel(paddr_i))
      3'h1:    rd_word[13:0] = r_r.ctrl[0];
      3'h2:    rd_word[13:0] = r_r.ctrl[1];
      3'h3:    rd_word[4:0]  = r_r.status;
      3'h4:    rd_word[4:0]  = r_r.mask;
      3'h5:    rd_word[10:0] = {ch_if[1].dtr_n, ch_if[0].dtr_n,
                                ch_if[1].rts_n, ch_if[0].rts_n,
                                r_r.sy2};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Next state: synchronisers, bus slave, registers, pin drivers
  always_comb begin
    r_nxt          = r_r;
    r_nxt.sy1      = pins_raw;                              // [RL4]
    r_nxt.sy2      = r_r.sy1;                               // [RL4]
    r_nxt.ack_prev = r_r.sy2[0];
    r_nxt.clr      = 5'h00;
    // Two-cycle access keeps every bus output on a flip-flop
    case (r_r.apb)
      scpc_pkg::APB_IDLE: begin
        if (bus_req) begin
          r_nxt.apb     = scpc_pkg::APB_ACK;
          r_nxt.pready  = 1'b1;
          r_nxt.pslverr = ~is_mapped;
          r_nxt.prdata  = pwrite_i ? 32'h0000_0000 : rd_word;
        end
      end
      scpc_pkg::APB_ACK: begin
        r_nxt.apb     = scpc_pkg::APB_IDLE;
        r_nxt.pready  = 1'b0;
        r_nxt.pslverr = 1'b0;
        if (bus_req && pwrite_i) begin
          case (reg_sel(paddr_i))
            3'h1: r_nxt.ctrl[0] = pwdata_i[13:0];
            // Channel B has no oscillator option
            3'h2: r_nxt.ctrl[1] = pwdata_i[13:0]
                                  & ~(14'h0001 << `SCPC_F_XTAL);  // [RL11]
            3'h4: r_nxt.mask = pwdata_i[4:0];
            default: r_nxt.mask = r_r.mask;
          endcase
        end else if (bus_req && reg_sel(paddr_i) == 3'h3) begin
          // Clear only what the read returned
          r_nxt.clr = r_r.prdata[4:0];
        end
      end
      default: begin
        r_nxt.apb    = scpc_pkg::APB_IDLE;
        r_nxt.pready = 1'b0;
      end
    endcase
    // A new event wins over a read-clear in the same cycle
    r_nxt.status  = (r_r.status & ~r_nxt.clr) | ev;
    r_nxt.int_lvl = |(r_nxt.status & r_nxt.mask);
    r_nxt.irq_oe  = r_nxt.int_lvl;                          // [RL2]
    r_nxt.irq_n   = ~r_nxt.int_lvl;                         // [RL2]
    r_nxt.data_oe = ~r_r.sy2[1] & ~r_r.sy2[2];              // [RL5]
  end

  // Single state register; all outputs except the channel pin, route, tick and oscillator ones are taken from it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_r <= '{sy1: 7'h7F, sy2: 7'h7F, ack_prev: 1'b1,
               ctrl: {`SCPC_CTRL_RST, `SCPC_CTRL_RST},
               mask: `SCPC_MASK_RST, apb: scpc_pkg::APB_IDLE,
               irq_n: 1'b1, default: '0};
    end else if (ce_i) begin
      r_r <= r_nxt;
    end
  end

  assign prdata_o                    = r_r.prdata;
  assign pready_o                    = r_r.pready;
  assign pslverr_o                   = r_r.pslverr;
  assign irq_n_o                     = r_r.irq_n;
  assign irq_oe_o                    = r_r.irq_oe;
  assign int_o                       = r_r.int_lvl;
  assign data_oe_o                   = r_r.data_oe;
  assign send_request_a_n_o          = ch_if[0].rts_n;
  assign send_request_b_n_o          = ch_if[1].rts_n;
  assign term_ready_or_dma_req_a_n_o = ch_if[0].dtr_n;
  assign term_ready_or_dma_req_b_n_o = ch_if[1].dtr_n;
  assign a_clk_route_o               = ch_if[0].route;
  assign b_clk_route_o               = ch_if[1].route;
  assign a_bit_tick_o                = ch_if[0].bit_tick;
  assign b_bit_tick_o                = ch_if[1].bit_tick;
  // Oscillator mode is only kept in the channel A word
  assign xtal_osc_en_o               = ch_if[0].osc_en;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_irq_pin;
    irq_oe_o == |(r_r.status & r_r.mask) && irq_n_o == !irq_oe_o
      && int_o == irq_oe_o;
  endproperty
  a_irq_pin: assert property (p_irq_pin)   // [RL2]
    else $error("interrupt pin disagrees with pending status");

  property p_irq_ack_in_n;
    ce_i && ack_fall |=> r_r.status[`SCPC_EV_IRQ_ACK_IN_N];
  endproperty
  a_irq_ack_in_n: assert property (p_irq_ack_in_n)   // [RL3]
    else $error("acknowledge edge not recorded");

  property p_sync;
    (ce_i && $stable(irq_ack_in_n_i))[*3] |-> r_r.sy2[0] == irq_ack_in_n_i;
  endproperty
  a_sync: assert property (p_sync)   // [RL4]
    else $error("acknowledge synchroniser too slow or wrong");

  property p_drv_on;
    (ce_i && !cs_n_i && !rd_n_i)[*4] |-> data_oe_o;
  endproperty
  a_drv_on: assert property (p_drv_on)   // [RL5]
    else $error("data drivers off during selected read");

  property p_drv_off;
    (ce_i && rd_n_i)[*4] |-> !data_oe_o;
  endproperty
  a_drv_off: assert property (p_drv_off)   // [RL5]
    else $error("data drivers on without read strobe");

  property p_xtal_b;
    !r_r.ctrl[1][`SCPC_F_XTAL] && !ch_if[1].osc_en;
  endproperty
  a_xtal_b: assert property (p_xtal_b)   // [RL11]
    else $error("oscillator enabled on channel B");

  property p_same_chan;
    ce_i && r_r.ctrl[0] == r_r.ctrl[1] && tx_empty_i[0] == tx_empty_i[1]
      && dma_req_i[0] == dma_req_i[1] && ch_if[0].rts_n == ch_if[1].rts_n
      |=> ch_if[0].rts_n == ch_if[1].rts_n
          && ch_if[0].dtr_n == ch_if[1].dtr_n;
  endproperty
  a_same_chan: assert property (p_same_chan)   // [RL13]
    else $error("channels differ under equal settings");

  property p_apb_ack;
    ce_i && bus_req && r_r.apb == scpc_pkg::APB_IDLE
      |=> pready_o ##1 !pready_o;
  endproperty
  a_apb_ack: assert property (p_apb_ack)
    else $error("bus answer not a single cycle after one wait");

endmodule : scpc_top

// *** verification/scpc_line_model.sv ***
// Far-side line model: clock pins, receive data, transmitter status
`timescale 1ns/1ps
module scpc_line_model #(
  parameter int HALF  = 8,
  parameter int DRAIN = 6
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [1:0] run_i,
  input  wire logic [1:0] send_i,
  output logic      [1:0] clk_n_o,
  output logic      [1:0] rxd_o,
  output logic      [1:0] tx_empty_o
);
  int ph [2];
  int dr [2];

  // Pin stands high outside runs, so no stray falling edge
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clk_n_o    <= 2'h3;
      rxd_o      <= 2'h3;
      tx_empty_o <= 2'h0;
      ph         <= '{0, 0};
      dr         <= '{0, 0};
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!run_i[c]) begin
          ph[c]      <= 0;
          clk_n_o[c] <= 1'b1;
          rxd_o[c]   <= 1'b1;
        end else if (ph[c] == HALF - 1) begin
          ph[c]      <= 0;
          clk_n_o[c] <= ~clk_n_o[c];
          rxd_o[c]   <= rxd_o[c] ^ clk_n_o[c]; // Data moves on falls
        end else begin
          ph[c] <= ph[c] + 1;
        end
        // Transmitter needs a while to drain after sending stops
        if (send_i[c]) begin
          dr[c]         <= 0;
          tx_empty_o[c] <= 1'b0;
        end else if (dr[c] < DRAIN) begin
          dr[c] <= dr[c] + 1;
        end else begin
          tx_empty_o[c] <= 1'b1;
        end
      end
    end
  end
endmodule : scpc_line_model

// *** verification/scpc_top_tb.sv ***
// Self-checking bench for the dual-channel serial pin controller
`timescale 1ns/1ps
`include "scpc_regs.svh"
module scpc_top_tb;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic        ack_n = 1'b1;
  logic        cs_n = 1'b1;
  logic        rd_n = 1'b1;
  logic        ce = 1'b1;
  logic [1:0]  dma = 2'h0;
  logic [1:0]  run = 2'h0;
  logic [1:0]  send = 2'h0;
  logic [31:0] rd;
  logic        er;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, irq_n, irq_oe, int_o, data_oe, xtal;
  wire  [1:0]  rts_n, dtr_n, tick, pclk_n, rxd, txe;
  wire  [3:0]  route [2];
  int          compares = 0;
  int          err_total = 0;

  scpc_top i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .irq_ack_in_n_i(ack_n), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .rx_tx_clock_pin_a_n_i(pclk_n[0]), .rx_tx_clock_pin_b_n_i(pclk_n[1]),
    .serial_in_a_i(rxd[0]), .serial_in_b_i(rxd[1]),
    .tx_empty_i(txe), .dma_req_i(dma),
    .send_request_a_n_o(rts_n[0]), .send_request_b_n_o(rts_n[1]),
    .term_ready_or_dma_req_a_n_o(dtr_n[0]),
    .term_ready_or_dma_req_b_n_o(dtr_n[1]),
    .irq_n_o(irq_n), .irq_oe_o(irq_oe), .int_o(int_o),
    .data_oe_o(data_oe), .a_clk_route_o(route[0]),
    .b_clk_route_o(route[1]), .a_bit_tick_o(tick[0]),
    .b_bit_tick_o(tick[1]), .xtal_osc_en_o(xtal));

  scpc_line_model i_line (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .run_i(run), .send_i(send),
    .clk_n_o(pclk_n), .rxd_o(rxd), .tx_empty_o(txe));

  // 200 MHz master clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    compares++;
    if (s !== e) begin
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      err_total++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) begin
      err_total++;
      results();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    // First edge lets channel and pin registers take the new word
    repeat (2) @(posedge clk_i);
  endtask : apb

  task automatic t_reset();
    chk({rts_n, dtr_n, irq_n, irq_oe, int_o, data_oe, xtal}, 9'h1F0);
    apb(1'b0, `SCPC_CTRL_A_OFS, 32'h0);
    chk({er, rd}, 33'h0);
    apb(1'b0, `SCPC_MASK_OFS, 32'h0);
    chk({er, rd}, 33'h0);
    // Unmapped place answers with an error and no data
    apb(1'b0, 12'h014, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
  endtask : t_reset

  task automatic t_rts(input int c);
    logic [11:0] a;
    a = c ? `SCPC_CTRL_B_OFS : `SCPC_CTRL_A_OFS;
    apb(1'b1, a, 32'h1);
    chk(rts_n[c], 1'b0);
    apb(1'b1, a, 32'h0);
    chk(rts_n[c], 1'b1);
    // Auto enable keeps the pin low until the transmitter drains
    send[c] <= 1'b1;
    apb(1'b1, a, 32'hD);
    apb(1'b1, a, 32'hC);
    apb(1'b1, `SCPC_MASK_OFS, 32'h1 << c);
    cyc(4);
    chk(rts_n[c], 1'b0);
    send[c] <= 1'b0;
    cyc(14);
    chk(rts_n[c], 1'b1);
    chk({irq_n, irq_oe, int_o}, 3'b011);
    apb(1'b0, `SCPC_STATUS_OFS, 32'h0);
    chk(rd & (32'h1 << c), 32'h1 << c);
    cyc(2);
    chk({irq_n, irq_oe, int_o}, 3'b100);
    apb(1'b1, `SCPC_MASK_OFS, 32'h0);
    apb(1'b1, a, 32'h30);
    chk(rts_n[c], 1'b0);
    apb(1'b1, a, 32'h10);
    chk(rts_n[c], 1'b1);
  endtask : t_rts

  task automatic t_dtr(input int c);
    logic [31:0] v [5];
    logic [4:0]  e;
    logic [11:0] a;
    v = '{32'h002, 32'h140, 32'h040, 32'h080, 32'h0C0};
    e = 5'b10100;
    a = c ? `SCPC_CTRL_B_OFS : `SCPC_CTRL_A_OFS;
    dma[c] <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, a, v[i]);
      chk(dtr_n[c], e[i]);
    end
    dma[c] <= 1'b0;
    apb(1'b1, a, 32'h080);
    chk(dtr_n[c], 1'b1);
  endtask : t_dtr

  // Each mode routes every falling pin edge; ticks divide by the rate
  task automatic t_clk(input int c);
    int m, nr, nt, n;
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? 1 : 8 << i;
      apb(1'b1, c ? `SCPC_CTRL_B_OFS : `SCPC_CTRL_A_OFS,
          32'h4 | (i << 9) | (i << 11));
      nr = 0;
      nt = 0;
      n = 0;
      run[c] <= 1'b1;
      while (nr < 2 * m && n < 5000) begin
        @(posedge clk_i);
        n++;
        nt += tick[c];
        if (route[c] !== 4'h0) begin
          nr++;
          chk(route[c], 4'h1 << i);
        end
      end
      run[c] <= 1'b0;
      repeat (20) begin
        @(posedge clk_i);
        nt += tick[c];
        nr += (route[c] !== 4'h0);
      end
      chk(nr, 2 * m);
      chk(nt, 2);
    end
  endtask : t_clk

  task automatic t_host();
    cs_n <= 1'b0;
    cyc(5);
    chk(data_oe, 1'b0);
    rd_n <= 1'b0;
    // Clock enable low freezes the synchronisers too
    ce   <= 1'b0;
    cyc(6);
    chk(data_oe, 1'b0);
    ce   <= 1'b1;
    cyc(2);
    chk(data_oe, 1'b0);
    cyc(3);
    chk(data_oe, 1'b1);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    cyc(5);
    chk(data_oe, 1'b0);
    apb(1'b1, `SCPC_MASK_OFS, 32'h10);
    apb(1'b0, `SCPC_STATUS_OFS, 32'h0);
    ack_n <= 1'b0;
    cyc(6);
    ack_n <= 1'b1;
    cyc(2);
    chk({irq_n, int_o}, 2'b01);
    apb(1'b0, `SCPC_STATUS_OFS, 32'h0);
    chk(rd & 32'h10, 32'h10);
    apb(1'b1, `SCPC_MASK_OFS, 32'h0);
  endtask : t_host

  // Oscillator option exists on channel A alone
  task automatic t_xtal();
    apb(1'b1, `SCPC_CTRL_A_OFS, 32'h2000);
    chk(xtal, 1'b1);
    apb(1'b1, `SCPC_CTRL_B_OFS, 32'h2000);
    apb(1'b0, `SCPC_CTRL_B_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `SCPC_CTRL_A_OFS, 32'h0);
    chk(xtal, 1'b0);
  endtask : t_xtal

  task automatic results();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // Main sequence after a four-cycle reset
  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    cyc(4);
    t_reset();
    for (int c = 0; c < 2; c++) begin
      t_rts(c);
      t_dtr(c);
      t_clk(c);
    end
    t_host();
    t_xtal();
    results();
  end
endmodule : scpc_top_tb
